/* File: design/acss_pkg.sv */
// constants and register map of the audio clock source selector
// Contract
// (R01) While clock auto set mode is on, the PLL reference field is ignored and the block picks the reference itself.
// (R02) With auto mode off, PLL reference code 0 takes the master clock pin and code 1 the bit clock.
// (R03) DSP divider source bits 2-0: 0 auto master, 1 PLL, 2 oscillator, 3 master pin, 4 bit clock, 5 pin route.
// (R04) DAC divider source bits 6-4 use the same six-way encoding as the DSP divider source.
// (R05) Oversample source bits 2-0: 0 DAC clock, 1 auto master, 2 PLL, 3 oscillator, 4 master pin, 5 bit clock, 6 pin.
// (R06) Charge-pump source bits 2-0 use the oversample encoding, 0 the DAC clock and 6 the pin route.
// (R07) Any unlisted PLL reference code leaves the PLL reference muted; the code sends such codes to the reference pin route instead.
// (R08) DSP pin route code 5 delivers the serial out pin; other codes give no clock.
// (R09) DAC pin route code 5 delivers the serial out pin; other codes give no clock.
// (R10) Oversample pin route code 5 delivers the serial out pin; other codes mute.
// (R11) Charge-pump pin route code 5 delivers the serial out pin; other codes mute.
// (R12) PLL reference pin route code 5 delivers the serial out pin; other codes mute. The one-bit reference field never selects this route.
// (R13) Each multiplexer switches sources without runt pulses, holding low between old and new source; a high output passes straight to the new source.
`default_nettype none
package acss_pkg;
   // register byte offsets (index times four)
   localparam logic [7:0] ACSS_IDX_REF_DSP = 8'h0D;
   localparam logic [7:0] ACSS_IDX_DAC_OSR = 8'h0E;
   localparam logic [7:0] ACSS_IDX_NCP     = 8'h0F;
   localparam logic [7:0] ACSS_IDX_ROUTE1  = 8'h10;
   localparam logic [7:0] ACSS_IDX_ROUTE2  = 8'h11;
   localparam logic [7:0] ACSS_IDX_ROUTE3  = 8'h12;
   localparam logic [7:0] ACSS_IDX_CTRL    = 8'h13;
   localparam logic [7:0] ACSS_IDX_STATUS  = 8'h14;
   localparam logic [9:0] ACSS_ADDR_REF_DSP = {ACSS_IDX_REF_DSP, 2'b00};
   localparam logic [9:0] ACSS_ADDR_DAC_OSR = {ACSS_IDX_DAC_OSR, 2'b00};
   localparam logic [9:0] ACSS_ADDR_NCP     = {ACSS_IDX_NCP, 2'b00};
   localparam logic [9:0] ACSS_ADDR_ROUTE1  = {ACSS_IDX_ROUTE1, 2'b00};
   localparam logic [9:0] ACSS_ADDR_ROUTE2  = {ACSS_IDX_ROUTE2, 2'b00};
   localparam logic [9:0] ACSS_ADDR_ROUTE3  = {ACSS_IDX_ROUTE3, 2'b00};
   localparam logic [9:0] ACSS_ADDR_CTRL    = {ACSS_IDX_CTRL, 2'b00};
   localparam logic [9:0] ACSS_ADDR_STATUS  = {ACSS_IDX_STATUS, 2'b00};
   // writable bit masks and reset values
   localparam logic [7:0] ACSS_MASK_REF_DSP = 8'h17;
   localparam logic [7:0] ACSS_MASK_PAIR    = 8'h77;
   localparam logic [7:0] ACSS_MASK_LOW3    = 8'h07;
   localparam logic [7:0] ACSS_MASK_CTRL    = 8'h01;
   localparam logic [7:0] ACSS_RST_REG      = 8'h00;
   localparam logic [7:0] ACSS_RST_CTRL     = 8'h01;
   // field positions
   localparam int ACSS_LO_POS  = 0;
   localparam int ACSS_HI_POS  = 4;
   localparam int ACSS_REF_POS = 4;
   // source codes, six-way set
   localparam logic [2:0] ACSS_S6_AUTO = 3'h0;
   localparam logic [2:0] ACSS_S6_PLL  = 3'h1;
   localparam logic [2:0] ACSS_S6_OSC  = 3'h2;
   localparam logic [2:0] ACSS_S6_MCLK = 3'h3;
   localparam logic [2:0] ACSS_S6_BCLK = 3'h4;
   localparam logic [2:0] ACSS_S6_PIN  = 3'h5;
   // source codes, seven-way set
   localparam logic [2:0] ACSS_S7_DAC  = 3'h0;
   localparam logic [2:0] ACSS_S7_AUTO = 3'h1;
   localparam logic [2:0] ACSS_S7_PLL  = 3'h2;
   localparam logic [2:0] ACSS_S7_OSC  = 3'h3;
   localparam logic [2:0] ACSS_S7_MCLK = 3'h4;
   localparam logic [2:0] ACSS_S7_BCLK = 3'h5;
   localparam logic [2:0] ACSS_S7_PIN  = 3'h6;
   // pin route and reference codes
   localparam logic [2:0] ACSS_ROUTE_SDO = 3'h5;
   localparam logic       ACSS_REF_MCLK  = 1'b0;
   localparam logic       ACSS_REF_BCLK  = 1'b1;
   // clean-switch timing: cycles held low between sources
   localparam int         ACSS_GAP_CYC   = 2;
   localparam logic [1:0] ACSS_GAP_LAST  = 2'(ACSS_GAP_CYC - 1);
   // AXI responses
   localparam logic [1:0] ACSS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ACSS_RESP_SLVERR = 2'h2;
   // number of output muxes: ref, dsp, dac, osr, ncp
   localparam int ACSS_NMUX = 5;
endpackage
`default_nettype wire

/* File: design/acss_top.sv */
// audio clock source selector with AXI4-Lite registers
`default_nettype none
module acss_top
   import acss_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [9:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [9:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic        mclk_pin_i,
   input  wire logic        bclk_pin_i,
   input  wire logic        osc_clk_i,
   input  wire logic        pll_clk_i,
   input  wire logic        serial_out_pin_i,
   input  wire logic        auto_master_clk_i,
   input  wire logic        auto_pll_ref_clk_i,
   output logic             pll_ref_clk_o,
   output logic             dsp_div_clk_o,
   output logic             dac_div_clk_o,
   output logic             osr_div_clk_o,
   output logic             ncp_div_clk_o,
   output logic [ACSS_NMUX-1:0] mux_busy_o
);
   // state of each glitch-free switch
   typedef enum logic [2:0] {
      ACSS_RUN  = 3'b001,
      ACSS_GAP  = 3'b010,
      ACSS_LOAD = 3'b100
   } acss_sw_t;

   logic [7:0] ref_dsp_q, dac_osr_q, ncp_q, route1_q, route2_q, route3_q, ctrl_q;
   logic [9:0] awaddr_q;
   logic       aw_held_q, w_held_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   // ---- AXI write path: address and data taken in either order
   wire do_write = aw_held_q & w_held_q & ~s_axi_bvalid_o;
   wire [7:0] wbyte = wdata_q[7:0];
   wire wlane = wstrb_q[0];
   wire hit_ref_dsp = awaddr_q == ACSS_ADDR_REF_DSP;
   wire hit_dac_osr = awaddr_q == ACSS_ADDR_DAC_OSR;
   wire hit_ncp     = awaddr_q == ACSS_ADDR_NCP;
   wire hit_route1  = awaddr_q == ACSS_ADDR_ROUTE1;
   wire hit_route2  = awaddr_q == ACSS_ADDR_ROUTE2;
   wire hit_route3  = awaddr_q == ACSS_ADDR_ROUTE3;
   wire hit_ctrl    = awaddr_q == ACSS_ADDR_CTRL;
   wire hit_status  = awaddr_q == ACSS_ADDR_STATUS;
   wire w_mapped = hit_ref_dsp | hit_dac_osr | hit_ncp | hit_route1 | hit_route2 | hit_route3
                   | hit_ctrl | hit_status;

   // channel handshakes
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         aw_held_q       <= 1'b0;
         w_held_q        <= 1'b0;
         awaddr_q        <= '0;
         wdata_q         <= '0;
         wstrb_q         <= '0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= ACSS_RESP_OKAY;
      end else begin
         s_axi_awready_o <= ~aw_held_q & ~s_axi_awready_o & ~s_axi_bvalid_o;
         s_axi_wready_o  <= ~w_held_q & ~s_axi_wready_o & ~s_axi_bvalid_o;
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata_i;
            wstrb_q  <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         if (do_write) begin
            aw_held_q      <= 1'b0;
            w_held_q       <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= w_mapped ? ACSS_RESP_OKAY : ACSS_RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // register storage; reserved bits stay zero
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ref_dsp_q <= ACSS_RST_REG;
         dac_osr_q <= ACSS_RST_REG;
         ncp_q     <= ACSS_RST_REG;
         route1_q  <= ACSS_RST_REG;
         route2_q  <= ACSS_RST_REG;
         route3_q  <= ACSS_RST_REG;
         ctrl_q    <= ACSS_RST_CTRL;
      end else if (do_write && wlane) begin
         if (hit_ref_dsp) ref_dsp_q <= wbyte & ACSS_MASK_REF_DSP;
         if (hit_dac_osr) dac_osr_q <= wbyte & ACSS_MASK_PAIR;
         if (hit_ncp)     ncp_q     <= wbyte & ACSS_MASK_LOW3;
         if (hit_route1)  route1_q  <= wbyte & ACSS_MASK_PAIR;
         if (hit_route2)  route2_q  <= wbyte & ACSS_MASK_PAIR;
         if (hit_route3)  route3_q  <= wbyte & ACSS_MASK_LOW3;
         if (hit_ctrl)    ctrl_q    <= wbyte & ACSS_MASK_CTRL;
      end
   end

   // ---- AXI read path, one read at a time
   wire [9:0] ra = s_axi_araddr_i;
   wire [7:0] rd_byte =
      (ra == ACSS_ADDR_REF_DSP) ? ref_dsp_q :
      (ra == ACSS_ADDR_DAC_OSR) ? dac_osr_q :
      (ra == ACSS_ADDR_NCP)     ? ncp_q     :
      (ra == ACSS_ADDR_ROUTE1)  ? route1_q  :
      (ra == ACSS_ADDR_ROUTE2)  ? route2_q  :
      (ra == ACSS_ADDR_ROUTE3)  ? route3_q  :
      (ra == ACSS_ADDR_CTRL)    ? ctrl_q    :
      (ra == ACSS_ADDR_STATUS)  ? {3'h0, mux_busy_o} : 8'h00;
   wire r_mapped = (ra == ACSS_ADDR_REF_DSP) | (ra == ACSS_ADDR_DAC_OSR) | (ra == ACSS_ADDR_NCP)
                 | (ra == ACSS_ADDR_ROUTE1) | (ra == ACSS_ADDR_ROUTE2) | (ra == ACSS_ADDR_ROUTE3)
                 | (ra == ACSS_ADDR_CTRL) | (ra == ACSS_ADDR_STATUS);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= '0;
         s_axi_rresp_o   <= ACSS_RESP_OKAY;
      end else begin
         s_axi_arready_o <= ~s_axi_arready_o & ~s_axi_rvalid_o;
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= {24'h000000, rd_byte};
            s_axi_rresp_o   <= r_mapped ? ACSS_RESP_OKAY : ACSS_RESP_SLVERR;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   // ---- field extraction
   wire       auto_mode  = ctrl_q[0];
   wire       ref_sel    = ref_dsp_q[ACSS_REF_POS];
   wire [2:0] dsp_src    = ref_dsp_q[ACSS_LO_POS +: 3];
   wire [2:0] dac_src    = dac_osr_q[ACSS_HI_POS +: 3];
   wire [2:0] osr_src    = dac_osr_q[ACSS_LO_POS +: 3];
   wire [2:0] ncp_src    = ncp_q[ACSS_LO_POS +: 3];
   wire [2:0] dsp_route  = route1_q[ACSS_HI_POS +: 3];
   wire [2:0] dac_route  = route1_q[ACSS_LO_POS +: 3];
   wire [2:0] ncp_route  = route2_q[ACSS_HI_POS +: 3];
   wire [2:0] osr_route  = route2_q[ACSS_LO_POS +: 3];
   wire [2:0] ref_route  = route3_q[ACSS_LO_POS +: 3];

   // (R08) dsp pin route to serial out
   wire dsp_pin = (dsp_route == ACSS_ROUTE_SDO) & serial_out_pin_i;
   // (R09) dac pin route to serial out
   wire dac_pin = (dac_route == ACSS_ROUTE_SDO) & serial_out_pin_i;
   // (R10) oversample pin route, else muted
   wire osr_pin = (osr_route == ACSS_ROUTE_SDO) & serial_out_pin_i;
   // (R11) charge-pump pin route, else muted
   wire ncp_pin = (ncp_route == ACSS_ROUTE_SDO) & serial_out_pin_i;
   // (R12) reference pin route; one-bit field never reaches it, kept for the wider code space
   wire ref_pin = (ref_route == ACSS_ROUTE_SDO) & serial_out_pin_i;

   // selection codes per mux, widened so the reference code fits the per-mux change detection
   // (R01) auto mode overrides the reference field
   wire [2:0] ref_code = auto_mode ? 3'h7 : {2'b00, ref_sel};
   wire [2:0] code [ACSS_NMUX];
   assign code[0] = ref_code;
   assign code[1] = dsp_src;
   assign code[2] = dac_src;
   assign code[3] = osr_src;
   assign code[4] = ncp_src;

   // (R02) reference: master pin or bit clock; (R07) other codes fall to the reference pin route
   wire ref_mux = auto_mode ? auto_pll_ref_clk_i :
                  (ref_sel == ACSS_REF_MCLK) ? mclk_pin_i :
                  (ref_sel == ACSS_REF_BCLK) ? bclk_pin_i : ref_pin;

   // (R03) dsp divider six-way source
   wire dsp_mux = (dsp_src == ACSS_S6_AUTO) ? auto_master_clk_i :
                  (dsp_src == ACSS_S6_PLL)  ? pll_clk_i  :
                  (dsp_src == ACSS_S6_OSC)  ? osc_clk_i  :
                  (dsp_src == ACSS_S6_MCLK) ? mclk_pin_i :
                  (dsp_src == ACSS_S6_BCLK) ? bclk_pin_i :
                  (dsp_src == ACSS_S6_PIN)  ? dsp_pin    : 1'b0;
   // (R04) dac divider, same encoding
   wire dac_mux = (dac_src == ACSS_S6_AUTO) ? auto_master_clk_i :
                  (dac_src == ACSS_S6_PLL)  ? pll_clk_i  :
                  (dac_src == ACSS_S6_OSC)  ? osc_clk_i  :
                  (dac_src == ACSS_S6_MCLK) ? mclk_pin_i :
                  (dac_src == ACSS_S6_BCLK) ? bclk_pin_i :
                  (dac_src == ACSS_S6_PIN)  ? dac_pin    : 1'b0;
   // (R05) oversample seven-way source, code 0 is the dac clock
   wire osr_mux = (osr_src == ACSS_S7_DAC)  ? dac_div_clk_o :
                  (osr_src == ACSS_S7_AUTO) ? auto_master_clk_i :
                  (osr_src == ACSS_S7_PLL)  ? pll_clk_i  :
                  (osr_src == ACSS_S7_OSC)  ? osc_clk_i  :
                  (osr_src == ACSS_S7_MCLK) ? mclk_pin_i :
                  (osr_src == ACSS_S7_BCLK) ? bclk_pin_i :
                  (osr_src == ACSS_S7_PIN)  ? osr_pin    : 1'b0;
   // (R06) charge pump, oversample encoding
   wire ncp_mux = (ncp_src == ACSS_S7_DAC)  ? dac_div_clk_o :
                  (ncp_src == ACSS_S7_AUTO) ? auto_master_clk_i :
                  (ncp_src == ACSS_S7_PLL)  ? pll_clk_i  :
                  (ncp_src == ACSS_S7_OSC)  ? osc_clk_i  :
                  (ncp_src == ACSS_S7_MCLK) ? mclk_pin_i :
                  (ncp_src == ACSS_S7_BCLK) ? bclk_pin_i :
                  (ncp_src == ACSS_S7_PIN)  ? ncp_pin    : 1'b0;

   wire [ACSS_NMUX-1:0] raw = {ncp_mux, osr_mux, dac_mux, dsp_mux, ref_mux};
   logic [ACSS_NMUX-1:0] clk_q;

   // (R13) per-mux switch: on a code change, once the output is low hold it low for a gap, then follow new source.
   // clocks are sampled at clk_i rate, so sources must run well below 25 MHz; the trade is simplicity.
   genvar g;
   generate
      for (g = 0; g < ACSS_NMUX; g++) begin : g_sw
         acss_sw_t   st_q;
         logic [2:0] code_q;
         logic [1:0] gap_q;
         logic       busy_q;
         wire changed = code[g] != code_q;
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               st_q      <= ACSS_LOAD;
               code_q    <= 3'h0;
               gap_q     <= 2'h0;
               clk_q[g]  <= 1'b0;
               busy_q    <= 1'b1;
            end else begin
               unique case (st_q)
                  ACSS_RUN: begin
                     clk_q[g] <= raw[g];
                     // a pending change already counts as busy, so software never trusts a stale source
                     busy_q   <= changed;
                     // (R13) stop only once the output is low; until then it already samples the new source
                     if (changed && !clk_q[g]) begin
                        st_q     <= ACSS_GAP;
                        gap_q    <= 2'h0;
                        clk_q[g] <= 1'b0;
                     end
                  end
                  ACSS_GAP: begin
                     clk_q[g] <= 1'b0;
                     gap_q    <= gap_q + 2'h1;
                     if (gap_q == ACSS_GAP_LAST) st_q <= ACSS_LOAD;
                  end
                  ACSS_LOAD: begin
                     // wait for new source low so the first pulse is whole
                     code_q   <= code[g];
                     clk_q[g] <= 1'b0;
                     if (!raw[g]) begin
                        st_q   <= ACSS_RUN;
                        busy_q <= 1'b0;
                     end
                  end
               endcase
            end
         end
         // busy comes straight from its own flop
         assign mux_busy_o[g] = busy_q;
      end
   endgenerate

   assign pll_ref_clk_o = clk_q[0];
   assign dsp_div_clk_o = clk_q[1];
   assign dac_div_clk_o = clk_q[2];
   assign osr_div_clk_o = clk_q[3];
   assign ncp_div_clk_o = clk_q[4];
endmodule
`default_nettype wire

/* File: tb/acss_top_assertions.sv */
// protocol and reference-mux checks for the clock source selector
`default_nettype none
module acss_top_assertions
   import acss_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [9:0]  s_axi_awaddr_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0]  s_axi_wstrb_i,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic        mclk_pin_i,
   input wire logic        bclk_pin_i,
   input wire logic        auto_pll_ref_clk_i,
   input wire logic        pll_ref_clk_o,
   input wire logic [ACSS_NMUX-1:0] mux_busy_o
);
   logic       ref_q, auto_q, st_q, bv_q;
   logic [9:0] aw_q;
   logic [7:0] w_q;
   logic [1:0] cfg;
   assign cfg = {auto_q, ref_q};
   // shadow of reference bit and auto mode, taken when an okay response rises
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ref_q <= 1'b0;
         auto_q <= 1'b1;
         bv_q <= 1'b0;
      end else begin
         bv_q <= s_axi_bvalid_o;
         if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
         if (s_axi_wvalid_i && s_axi_wready_o) w_q <= s_axi_wdata_i[7:0];
         if (s_axi_wvalid_i && s_axi_wready_o) st_q <= s_axi_wstrb_i[0];
         if (s_axi_bvalid_o && !bv_q && st_q && aw_q == ACSS_ADDR_REF_DSP) ref_q <= w_q[ACSS_REF_POS];
         if (s_axi_bvalid_o && !bv_q && st_q && aw_q == ACSS_ADDR_CTRL) auto_q <= w_q[0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read response dropped early");
   a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[1:6] s_axi_bvalid_o)
      else $error("write answer late");
   a_ref_from_mclk: assert property (!mux_busy_o[0] && !$past(mux_busy_o[0]) && cfg == $past(cfg, 4)
      && cfg == 2'b00 |-> pll_ref_clk_o == $past(mclk_pin_i)) else $error("reference not master pin");
   a_ref_from_bclk: assert property (!mux_busy_o[0] && !$past(mux_busy_o[0]) && cfg == $past(cfg, 4)
      && cfg == 2'b01 |-> pll_ref_clk_o == $past(bclk_pin_i)) else $error("reference not bit clock");
   a_ref_auto_pick: assert property (!mux_busy_o[0] && !$past(mux_busy_o[0]) && cfg == $past(cfg, 4)
      && auto_q |-> pll_ref_clk_o == $past(auto_pll_ref_clk_i)) else $error("auto reference wrong");
   a_switch_low: assert property (mux_busy_o[0] && $past(mux_busy_o[0]) && !$past(pll_ref_clk_o)
      |-> !pll_ref_clk_o) else $error("pulse during switch");
endmodule
bind acss_top acss_top_assertions chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(s_axi_awaddr_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
   .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .mclk_pin_i(mclk_pin_i),
   .bclk_pin_i(bclk_pin_i), .auto_pll_ref_clk_i(auto_pll_ref_clk_i), .pll_ref_clk_o(pll_ref_clk_o),
   .mux_busy_o(mux_busy_o));
`default_nettype wire

/* File: tb/acss_top_tb.sv */
// self-checking bench for the clock source selector
`default_nettype none
module acss_top_tb;
   import acss_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, src_run = 1'b0;
   logic [9:0]  aw = '0, ar = '0;
   logic [31:0] wd = '0, rd;
   logic [3:0]  ws = '0;
   logic        awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, awr, wr, bv, arr, rv, auto_b, dac_p;
   logic [1:0]  br, rr;
   logic [6:0]  src_q = '0;
   logic [4:0]  clk_o, busy;
   logic [2:0]  code [5], route [5];
   int          err_count = 0, n_checks = 0;
   localparam logic [9:0] ADDRS [8] = '{ACSS_ADDR_REF_DSP, ACSS_ADDR_DAC_OSR, ACSS_ADDR_NCP, ACSS_ADDR_ROUTE1,
      ACSS_ADDR_ROUTE2, ACSS_ADDR_ROUTE3, ACSS_ADDR_CTRL, ACSS_ADDR_STATUS};
   localparam logic [7:0] MASKS [8] = '{8'h17, 8'h77, 8'h07, 8'h77, 8'h77, 8'h07, 8'h01, 8'h00};
   always #10 clk_i = ~clk_i;
   // source order: mclk bclk osc pll serial-out auto-master auto-ref
   always @(posedge clk_i) if (src_run) src_q <= 7'($urandom);
   acss_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
      .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brd), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd),
      .mclk_pin_i(src_q[0]), .bclk_pin_i(src_q[1]), .osc_clk_i(src_q[2]), .pll_clk_i(src_q[3]),
      .serial_out_pin_i(src_q[4]), .auto_master_clk_i(src_q[5]), .auto_pll_ref_clk_i(src_q[6]),
      .pll_ref_clk_o(clk_o[0]), .dsp_div_clk_o(clk_o[1]), .dac_div_clk_o(clk_o[2]), .osr_div_clk_o(clk_o[3]),
      .ncp_div_clk_o(clk_o[4]), .mux_busy_o(busy));
   task automatic results;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // a wait that used up its bound ends the run
   task automatic tmo(input int n);
      if (n >= 300) begin
         err_count++;
         results();
      end
   endtask
   task automatic axi_wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
      int n;
      @(posedge clk_i);
      aw <= a;
      wd <= {24'h0, d};
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      n = 0;
      while (n < 300) begin
         @(posedge clk_i);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         n++;
         if (bv) break;
      end
      r = br;
      brd <= 1'b0;
      tmo(n);
   endtask
   task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk_i);
      ar <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      n = 0;
      while (n < 300) begin
         @(posedge clk_i);
         if (arr) arv <= 1'b0;
         n++;
         if (rv) break;
      end
      d = rd;
      r = rr;
      rrd <= 1'b0;
      tmo(n);
   endtask
   // six-way divider encoding, pin route passes serial out only on code 5
   function automatic logic six(input logic [2:0] c, input logic [2:0] r);
      case (c)
         3'h0: six = src_q[5];
         3'h1: six = src_q[3];
         3'h2: six = src_q[2];
         3'h3: six = src_q[0];
         3'h4: six = src_q[1];
         3'h5: six = (r == 3'h5) ? src_q[4] : 1'b0;
         default: six = 1'b0;
      endcase
   endfunction
   // seven-way set is the six-way set shifted up; code 0 takes the dac output, one cycle behind its source
   function automatic logic exp_clk(input int m);
      if (m == 0) exp_clk = auto_b ? src_q[6] : (code[0][0] ? src_q[1] : src_q[0]);
      else if (m < 3) exp_clk = six(code[m], route[m]);
      else if (code[m] == 3'h0) exp_clk = dac_p;
      else exp_clk = (code[m] == 3'h7) ? 1'b0 : six(code[m] - 3'h1, route[m]);
   endfunction
   initial begin
      int i, m, k, j;
      logic [1:0] r;
      logic [31:0] d;
      logic [7:0] v, v0;
      logic [4:0] e;
      k = $urandom(39);
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // reset values, then masked read-back of every field
      for (i = 0; i < 8; i++) begin
         axi_rd(ADDRS[i], d, r);
         check(d, (i == 6) ? 32'h1 : 32'h0);
      end
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom);
         if (i == 0) v0 = v;
         axi_wr(ADDRS[i], v, 4'hF, r);
         check(r, ACSS_RESP_OKAY);
         axi_rd(ADDRS[i], d, r);
         check(d, {24'h0, v & MASKS[i]});
      end
      // lane 0 off leaves the byte alone; unmapped places are refused
      axi_wr(ADDRS[7], 8'hFF, 4'hE, r);
      axi_wr(ADDRS[0], 8'hFF, 4'hE, r);
      check({30'h0, r}, {30'h0, ACSS_RESP_OKAY});
      axi_rd(ADDRS[0], d, r);
      check(d, {24'h0, v0 & MASKS[0]});
      axi_wr(10'h000, 8'h55, 4'hF, r);
      check(r, ACSS_RESP_SLVERR);
      axi_rd(10'h3FC, d, r);
      check(d, 32'h0);
      check({30'h0, r}, {30'h0, ACSS_RESP_SLVERR});
      src_run <= 1'b1;
      for (i = 0; i < 40; i++) begin
         auto_b = (i % 3 == 2);
         for (m = 0; m < 5; m++) begin
            code[m] = (i < 16) ? 3'(i) : 3'($urandom);
            route[m] = i[3] ? 3'h5 : 3'($urandom);
         end
         axi_wr(ACSS_ADDR_REF_DSP, {3'h0, code[0][0], 1'b0, code[1]}, 4'hF, r);
         axi_wr(ACSS_ADDR_DAC_OSR, {1'b0, code[2], 1'b0, code[3]}, 4'hF, r);
         axi_wr(ACSS_ADDR_NCP, {5'h0, code[4]}, 4'hF, r);
         axi_wr(ACSS_ADDR_ROUTE1, {1'b0, route[1], 1'b0, route[2]}, 4'hF, r);
         axi_wr(ACSS_ADDR_ROUTE2, {1'b0, route[4], 1'b0, route[3]}, 4'hF, r);
         axi_wr(ACSS_ADDR_ROUTE3, {5'h0, route[0]}, 4'hF, r);
         axi_wr(ACSS_ADDR_CTRL, {7'h0, auto_b}, 4'hF, r);
         repeat (4) @(posedge clk_i);
         k = 0;
         while (busy !== 5'h0 && k < 300) begin
            @(posedge clk_i);
            k++;
         end
         tmo(k);
         #1;
         // each output follows its chosen source one cycle late; the first pass only primes the dac history
         for (j = 0; j < 9; j++) begin
            for (m = 0; m < 5; m++) e[m] = exp_clk(m);
            dac_p = e[2];
            @(posedge clk_i);
            #1;
            if (j > 0) check(clk_o, e);
         end
      end
      // second reset in mid-run restores the defaults
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      axi_rd(ACSS_ADDR_REF_DSP, d, r);
      check(d, 32'h0);
      axi_rd(ACSS_ADDR_CTRL, d, r);
      check(d, 32'h1);
      results();
   end
endmodule
`default_nettype wire
